// file: include/tam_pkg.sv
package tam_pkg;

	localparam int CLK_HZ = 20_000_000;
	localparam int HALF_SEC_DIV = CLK_HZ / 2;
	localparam int DIV_W = 25;
	localparam int SEC_PER_MIN = 60;
	localparam int TIMEOUT_S = 15;
	localparam int DELAY_MIN = 45;
	localparam int SIL_SHORT_MIN = 5;
	localparam int SIL_LONG_MIN = 45;
	localparam logic [5:0] MENU_TIMEOUT_HALF = 6'(TIMEOUT_S * 2);
	localparam logic [12:0] DELAY_HALF = 13'(DELAY_MIN * SEC_PER_MIN * 2);
	localparam logic [12:0] SIL_SHORT_HALF =
		13'(SIL_SHORT_MIN * SEC_PER_MIN * 2);
	localparam logic [12:0] SIL_LONG_HALF =
		13'(SIL_LONG_MIN * SEC_PER_MIN * 2);
	localparam logic [1:0] FLASH_HALVES = 2'h2;

	typedef logic signed [9:0] tam_temp_type;
	localparam tam_temp_type LIMIT_MIN = -10'sh028;
	localparam tam_temp_type LIMIT_MAX = 10'sh0c7;
	localparam tam_temp_type CAL_MIN = -10'sh01e;
	localparam tam_temp_type CAL_MAX = 10'sh01e;
	localparam tam_temp_type UPPER_RST = 10'sh032;
	localparam tam_temp_type LOWER_RST = 10'sh000;
	localparam tam_temp_type CAL_RST = 10'sh000;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_LIMITS = 8'h08;
	localparam logic [7:0] ADDR_LOGS = 8'h0c;
	localparam logic [7:0] ADDR_CAL = 8'h10;
	localparam int CTRL_RESET_BIT = 0;
	localparam int CTRL_LOCK_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MENU_RUN = 3'h0,
		MENU_HI_LIM = 3'h1,
		MENU_LO_LIM = 3'h3,
		MENU_MAX = 3'h2,
		MENU_MIN = 3'h6,
		MENU_CAL = 3'h7,
		MENU_DONE = 3'h5
	} tam_menu_type;

	typedef struct packed {
		logic delay_on;
		logic manual_reset;
		logic sil3;
		logic sil4;
	} tam_dip_type;

	typedef struct packed {
		tam_menu_type menu;
		logic cfg_taken;
		tam_dip_type dip;
		logic [2:0] btn_prev;
		logic rst_prev;
		logic pwr_prev;
		logic sw_rst;
		logic lock;
		logic [DIV_W-1:0] div_cnt;
		logic half_tick;
		logic phase;
		logic [5:0] idle_cnt;
		logic [1:0] flash_cnt;
		tam_temp_type upper;
		tam_temp_type lower;
		tam_temp_type cal;
		tam_temp_type max_log;
		tam_temp_type min_log;
		tam_temp_type edit_upper;
		tam_temp_type edit_lower;
		tam_temp_type edit_cal;
		tam_temp_type disp;
		logic [12:0] exc_cnt;
		logic [12:0] sil_cnt;
		logic alarm;
		logic audible;
		logic blank;
		logic batt;
		logic power_out;
		logic aw_got;
		logic w_got;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} tam_state_type;

endpackage

// file: logic/tam_monitor.sv
// Operation
// - Set steps limits, logs, then offset
// - Upper limit held within -40..199
// - Lower limit held within -40..199
// - Track maximum; reset press clears it
// - Track minimum; reset press clears it
// - Offset -30..30 added before display
// - Up/down step one degree; set accepts
// - Idle over 15 s abandons edits
// - Save only on completion, flash once
// - Alarm immediate or after 45 minutes
// - Auto mode clears alarm on recovery
// - Manual mode latches until reset press
// - Reset press silences audible alarm
// - Switches pick none, 5 or 45 min silence
// - Both silence switches disable all alarms
// - Three dots while battery low
// - After power loss, reset shows and sounds
// - Active alarm flashes the display
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module tam_monitor
	import tam_pkg::*;
#(
	parameter logic [DIV_W-1:0] HALF_SEC_CYCLES = DIV_W'(HALF_SEC_DIV)
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic btn_set,
	input wire logic btn_up,
	input wire logic btn_down,
	input wire logic btn_reset,
	input wire tam_temp_type temp_in,
	input wire tam_dip_type dip_sw,
	input wire logic batt_low,
	input wire logic power_lost,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output tam_temp_type disp_value,
	output logic disp_blank,
	output tam_menu_type menu_item,
	output logic alarm_audible,
	output logic alarm_relay,
	output logic batt_dots
);
	tam_state_type st;
	tam_state_type n;
	logic set_p;
	logic up_p;
	logic down_p;
	logic rst_p;
	logic disabled;
	logic exc;
	logic armed;
	logic [12:0] sil_lim;
	tam_temp_type shown_now;
	function automatic tam_temp_type clamp(input logic signed [10:0] v,
		input tam_temp_type lo, input tam_temp_type hi);
		clamp = (v < 11'(lo)) ? lo : (v > 11'(hi)) ? hi : v[9:0];
	endfunction
	function automatic tam_temp_type step(input tam_temp_type v,
		input logic up, input logic down, input tam_temp_type lo,
		input tam_temp_type hi);
		step = clamp(11'(v) + (up ? 11'sh001 :
			down ? 11'sh7ff : 11'sh000), lo, hi);
	endfunction
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = a[7:2] <= ADDR_CAL[7:2];
	endfunction
	function automatic logic [15:0] ext(input tam_temp_type v);
		ext = {{6{v[9]}}, v};
	endfunction

	////////////////////////////////////////////////////////////////////
	always_comb begin
		n = st;
		set_p = btn_set & ~st.btn_prev[2] & ~st.lock;
		up_p = btn_up & ~st.btn_prev[1] & ~st.lock;
		down_p = btn_down & ~st.btn_prev[0] & ~st.lock;
		rst_p = (btn_reset & ~st.rst_prev) | st.sw_rst;
		disabled = st.dip.sil3 & st.dip.sil4;
		shown_now = clamp(11'(temp_in) + 11'(st.cal), LIMIT_MIN,
			LIMIT_MAX);
		exc = (shown_now > st.upper) || (shown_now < st.lower);
		armed = exc && (!st.dip.delay_on || st.exc_cnt == DELAY_HALF);
		case ({st.dip.sil3, st.dip.sil4})
			2'h1: sil_lim = SIL_SHORT_HALF;
			2'h2: sil_lim = SIL_LONG_HALF;
			default: sil_lim = 13'h0000;
		endcase
		n.btn_prev = {btn_set, btn_up, btn_down};
		n.rst_prev = btn_reset;
		n.pwr_prev = power_lost;
		n.sw_rst = 1'b0;
		n.batt = batt_low;
		// Half-second divider; seconds and minutes count these pulses
		n.half_tick = 1'b0;
		if (st.div_cnt == HALF_SEC_CYCLES - 1'b1) begin
			n.div_cnt = '0;
			n.half_tick = 1'b1;
			n.phase = ~st.phase;
		end else begin
			n.div_cnt = st.div_cnt + 1'b1;
		end
		if (st.half_tick && st.flash_cnt != 2'h0) begin
			n.flash_cnt = st.flash_cnt - 2'h1;
		end
		if (!st.cfg_taken) begin
			// Switches are read once, at the first edge after reset
			n.cfg_taken = 1'b1;
			n.dip = dip_sw;
			n.upper = UPPER_RST;
			n.lower = LOWER_RST;
			n.cal = CAL_RST;
			n.max_log = shown_now;
			n.min_log = shown_now;
		end else begin
			////////////////////////////////////////////////////////////
			if (rst_p) begin
				n.max_log = shown_now;
				n.min_log = shown_now;
			end else begin
				if (shown_now > st.max_log) begin
					n.max_log = shown_now;
				end
				if (shown_now < st.min_log) begin
					n.min_log = shown_now;
				end
			end
			////////////////////////////////////////////////////////////
			if (set_p || up_p || down_p) begin
				n.idle_cnt = 6'h00;
			end else if (st.half_tick && st.menu != MENU_RUN) begin
				n.idle_cnt = st.idle_cnt + 6'h01;
			end
			// Edits live in shadow copies, so dropping out discards them
			if (st.menu != MENU_RUN && st.idle_cnt > MENU_TIMEOUT_HALF)
			begin
				n.menu = MENU_RUN;
			end else begin
				case (st.menu)
					MENU_RUN: begin
						if (set_p) begin
							n.menu = MENU_HI_LIM;
							n.edit_upper = st.upper;
							n.edit_lower = st.lower;
							n.edit_cal = st.cal;
						end
					end
					MENU_HI_LIM: begin
						if (set_p) begin
							n.menu = MENU_LO_LIM;
						end else begin
							n.edit_upper = step(st.edit_upper, up_p,
								down_p, LIMIT_MIN, LIMIT_MAX);
						end
					end
					MENU_LO_LIM: begin
						if (set_p) begin
							n.menu = MENU_MAX;
						end else begin
							n.edit_lower = step(st.edit_lower, up_p,
								down_p, LIMIT_MIN, LIMIT_MAX);
						end
					end
					MENU_MAX: begin
						if (set_p) begin
							n.menu = MENU_MIN;
						end
					end
					MENU_MIN: begin
						if (set_p) begin
							n.menu = MENU_CAL;
						end
					end
					MENU_CAL: begin
						if (set_p) begin
							n.menu = MENU_DONE;
							n.upper = st.edit_upper;
							n.lower = st.edit_lower;
							n.cal = st.edit_cal;
							n.flash_cnt = FLASH_HALVES;
						end else begin
							n.edit_cal = step(st.edit_cal, up_p, down_p,
								CAL_MIN, CAL_MAX);
						end
					end
					MENU_DONE: begin
						if (set_p) begin
							n.menu = MENU_RUN;
						end
					end
					default: begin
						n.menu = MENU_RUN;
					end
				endcase
			end
			////////////////////////////////////////////////////////////
			if (!exc) begin
				n.exc_cnt = 13'h0000;
			end else if (st.half_tick && st.exc_cnt != DELAY_HALF) begin
				n.exc_cnt = st.exc_cnt + 13'h0001;
			end
			if (st.audible && st.half_tick && sil_lim != 13'h0000) begin
				n.sil_cnt = st.sil_cnt + 13'h0001;
			end
			if (disabled) begin
				n.alarm = 1'b0;
				n.audible = 1'b0;
			end else begin
				if (armed && !st.alarm) begin
					n.alarm = 1'b1;
					n.audible = 1'b1;
					n.sil_cnt = 13'h0000;
				end else if (!exc && !st.dip.manual_reset) begin
					// A power-out sounder is no excursion; recovery keeps it
					n.alarm = 1'b0;
					n.audible = st.audible && !st.alarm;
				end else if (rst_p && !exc) begin
					n.alarm = 1'b0;
				end
				if (rst_p) begin
					n.audible = 1'b0;
				end else if (sil_lim != 13'h0000 && st.sil_cnt >= sil_lim)
				begin
					n.audible = 1'b0;
				end
			end
			// Only a fresh loss arms the dark display, not the level
			if (power_lost && !st.pwr_prev) begin
				n.power_out = 1'b1;
			end else if (st.power_out && rst_p) begin
				n.power_out = 1'b0;
				n.audible = 1'b1;
				n.sil_cnt = 13'h0000;
			end
		end
		case (n.menu)
			MENU_HI_LIM: n.disp = n.edit_upper;
			MENU_LO_LIM: n.disp = n.edit_lower;
			MENU_MAX: n.disp = n.max_log;
			MENU_MIN: n.disp = n.min_log;
			MENU_CAL: n.disp = n.edit_cal;
			default: n.disp = shown_now;
		endcase
		n.blank = n.power_out || n.flash_cnt == 2'h1 ||
			(n.alarm && !disabled && n.phase);
		////////////////////////////////////////////////////////////////
		if (s_axi_awvalid && st.awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && st.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (st.aw_got && st.w_got && !st.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = addr_ok(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if ({st.awaddr[7:2], 2'h0} == ADDR_CTRL && st.wstrb[0]) begin
				n.sw_rst = st.wdata[CTRL_RESET_BIT];
				n.lock = st.wdata[CTRL_LOCK_BIT];
			end
		end
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		if (st.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && st.arready) begin
			n.rvalid = 1'b1;
			n.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			if ({s_axi_araddr[7:2], 2'h0} == ADDR_CTRL) begin
				n.rdata = {30'h0, st.lock, 1'b0};
			end else if ({s_axi_araddr[7:2], 2'h0} == ADDR_STATUS) begin
				n.rdata = {20'h0, st.dip, 1'b0, st.menu, st.power_out,
					st.batt, st.audible, st.alarm};
			end else if ({s_axi_araddr[7:2], 2'h0} == ADDR_LIMITS) begin
				n.rdata = {ext(st.lower), ext(st.upper)};
			end else if ({s_axi_araddr[7:2], 2'h0} == ADDR_LOGS) begin
				n.rdata = {ext(st.min_log), ext(st.max_log)};
			end else if ({s_axi_araddr[7:2], 2'h0} == ADDR_CAL) begin
				n.rdata = {ext(shown_now), ext(st.cal)};
			end else begin
				n.rdata = 32'h0000_0000;
			end
		end
		n.arready = !n.rvalid;
	end
	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end
	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rdata = st.rdata;
	assign disp_value = st.disp;
	assign disp_blank = st.blank;
	assign menu_item = st.menu;
	assign alarm_audible = st.audible;
	assign alarm_relay = st.alarm;
	assign batt_dots = st.batt;
endmodule

// file: verif/tam_checks_assertions.sv
`timescale 1ns/1ps
module tam_checks
	import tam_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic btn_set,
	input wire logic btn_down,
	input wire logic btn_reset,
	input wire tam_dip_type dip_sw,
	input wire logic power_lost,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire tam_temp_type disp_value,
	input wire logic disp_blank,
	input wire tam_menu_type menu_item,
	input wire logic alarm_audible,
	input wire logic alarm_relay
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write response dropped");
	menu_order_a: assert property (
		$rose(btn_set) && menu_item == MENU_HI_LIM
		|-> ##2 menu_item == MENU_LO_LIM) else $error("menu order");
	menu_return_a: assert property (
		$rose(btn_set) && menu_item == MENU_DONE
		|-> ##2 menu_item == MENU_RUN) else $error("menu not left");
	cal_step_a: assert property (
		$rose(btn_down) && menu_item == MENU_CAL && disp_value > CAL_MIN
		|-> ##2 disp_value == $past(disp_value, 2) - 10'sh001)
		else $error("offset step");
	done_flash_a: assert property (
		$changed(menu_item) && menu_item == MENU_DONE
		|-> ##[1:12] disp_blank) else $error("no save flash");
	reset_silence_a: assert property (
		$rose(btn_reset) && alarm_audible && !power_lost
		|-> ##2 !alarm_audible) else $error("sounder kept on");
	no_alarm_a: assert property (dip_sw.sil3 && dip_sw.sil4
		|-> !alarm_relay && !alarm_audible) else $error("alarm not off");
	// Bound assumes the short half-second tick used in simulation
	alarm_flash_a: assert property ($rose(alarm_relay)
		|-> ##[1:12] $changed(disp_blank)) else $error("no flashing");
endmodule

// file: verif/tam_operator.sv
`timescale 1ns/1ps
module tam_operator
	import tam_pkg::*;
(
	input wire logic clk_sys,
	output logic btn_set,
	output logic btn_up,
	output logic btn_down,
	output logic btn_reset
);
	// Released buttons read low, as the panel lines have pull-downs
	logic [3:0] held_r = 4'h0;
	assign {btn_reset, btn_down, btn_up, btn_set} = held_r;
	// Held and released for 3 cycles each, above the minimum spacing
	task press(input int b);
		@(posedge clk_sys);
		held_r[b] <= 1'b1;
		repeat (3) @(posedge clk_sys);
		held_r[b] <= 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
endmodule

// file: verif/tam_monitor_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tam_monitor_bench
	import tam_pkg::*;
;
	logic clk_sys, rst_n, batt_low, power_lost;
	logic btn_set, btn_up, btn_down, btn_reset;
	tam_temp_type temp_in, disp_value;
	tam_dip_type dip_sw;
	tam_menu_type menu_item;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic disp_blank, alarm_audible, alarm_relay, batt_dots;
	int miscompares = 0;
	int checks = 0;
	////////////////////////////////////////////////////////////////////////
	tam_monitor #(.HALF_SEC_CYCLES(25'h4)) i_tam_monitor(.clk_sys, .rst_n,
		.btn_set, .btn_up, .btn_down, .btn_reset, .temp_in, .dip_sw,
		.batt_low, .power_lost, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .disp_value,
		.disp_blank, .menu_item, .alarm_audible, .alarm_relay, .batt_dots);
	tam_operator i_tam_operator(.clk_sys, .btn_set, .btn_up, .btn_down,
		.btn_reset);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task push(input int b, input int n);
		repeat (n) i_tam_operator.press(b);
	endtask
	task do_reset(input tam_dip_type d);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		dip_sw <= d;
		temp_in <= 10'sh014;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		cyc(3);
	endtask
	task set_temp(input tam_temp_type t, input int n);
		@(posedge clk_sys);
		temp_in <= t;
		cyc(n);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw, w, b;
		logic [1:0] r;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge clk_sys);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		`CHK(r, e)
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic ar, r;
		logic [31:0] d;
		logic [1:0] rr;
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge clk_sys);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			d = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk_sys);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		`CHK(d, e)
		`CHK(rr, er)
	endtask
	task stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Tests need about 25600 cycles; over twice that means a hang
	initial begin
		repeat (60000) @(posedge clk_sys);
		miscompares++;
		stop_test();
	end
	initial begin
		rst_n <= 1'b0;
		batt_low <= 1'b0;
		power_lost <= 1'b0;
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr} <= 10'h0;
		{s_axi_araddr, s_axi_wdata} <= 40'h0;
		do_reset(4'h0);
		rd(ADDR_LIMITS, 32'h0000_0032, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		$display("test defaults done");
		push(0, 1);
		`CHK(menu_item, MENU_HI_LIM)
		push(1, 1);
		`CHK(disp_value, 10'sh033)
		push(0, 1);
		push(2, 2);
		`CHK(disp_value, -10'sh002)
		push(0, 3);
		`CHK(menu_item, MENU_CAL)
		push(2, 3);
		`CHK(disp_value, -10'sh003)
		rd(ADDR_LIMITS, 32'h0000_0032, RESP_OKAY);
		push(0, 1);
		`CHK(menu_item, MENU_DONE)
		rd(ADDR_LIMITS, 32'hfffe_0033, RESP_OKAY);
		rd(ADDR_CAL, 32'h0011_fffd, RESP_OKAY);
		push(0, 1);
		`CHK(menu_item, MENU_RUN)
		`CHK(disp_value, 10'sh011)
		push(0, 1);
		push(1, 160);
		`CHK(disp_value, 10'sh0c7)
		cyc(160);
		`CHK(menu_item, MENU_RUN)
		rd(ADDR_LIMITS, 32'hfffe_0033, RESP_OKAY);
		$display("test menu done");
		set_temp(10'sh03c, 6);
		`CHK({alarm_relay, alarm_audible}, 2'h3)
		push(3, 1);
		`CHK({alarm_relay, alarm_audible}, 2'h2)
		set_temp(10'sh014, 6);
		`CHK(alarm_relay, 1'b0)
		wr(ADDR_CTRL, 32'h1, RESP_OKAY);
		set_temp(10'sh01e, 4);
		set_temp(10'sh002, 4);
		set_temp(10'sh014, 4);
		rd(ADDR_LOGS, 32'hffff_001b, RESP_OKAY);
		wr(8'h20, 32'h1, RESP_SLVERR);
		wr(ADDR_CTRL, 32'h2, RESP_OKAY);
		push(0, 1);
		`CHK(menu_item, MENU_RUN)
		rd(ADDR_CTRL, 32'h2, RESP_OKAY);
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		@(posedge clk_sys) batt_low <= 1'b1;
		cyc(2);
		`CHK(batt_dots, 1'b1)
		@(posedge clk_sys) power_lost <= 1'b1;
		cyc(4);
		`CHK(disp_blank, 1'b1)
		push(3, 1);
		`CHK(alarm_audible, 1'b1)
		`CHK(disp_blank, 1'b0)
		@(posedge clk_sys) power_lost <= 1'b0;
		$display("test auto alarm done");
		do_reset(4'hd);
		@(posedge clk_sys) dip_sw <= 4'h0;
		rd(ADDR_STATUS, 32'h0000_0d04, RESP_OKAY);
		set_temp(10'sh03c, 100);
		`CHK(alarm_relay, 1'b0)
		cyc(21520);
		`CHK({alarm_relay, alarm_audible}, 2'h3)
		cyc(2420);
		`CHK({alarm_relay, alarm_audible}, 2'h2)
		set_temp(10'sh014, 10);
		`CHK(alarm_relay, 1'b1)
		push(3, 1);
		`CHK(alarm_relay, 1'b0)
		$display("test delayed alarm done");
		do_reset(4'h3);
		set_temp(10'sh03c, 20);
		`CHK({alarm_relay, alarm_audible}, 2'h0)
		$display("test disabled alarm done");
		stop_test();
	end
endmodule
bind tam_monitor tam_checks i_tam_checks(.clk_sys, .rst_n, .btn_set,
	.btn_down, .btn_reset, .dip_sw, .power_lost, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready,
	.disp_value, .disp_blank, .menu_item, .alarm_audible, .alarm_relay);
